/* File: scr_regs.sv */
// top of the serial configuration and identification register block
`timescale 1ns/100ps
// Operation
// - soft reset restores all but interface registers
// - ascend: address increments, wraps top to zero
// - descend: address decrements, wraps zero to top
// - power mode 00 means normal full operation
// - power mode 11 means lowest power, serial alive
// - power mode 00 or 11 write overwrites power-down bytes a and b once
// - device class code in low nibble, upper zero
// - part code low and high byte registers
// - read-only revision code register
// - read-only maker code low byte
// - read-only maker code high byte next
module scr_regs
    import scr_pkg::*;
#(
    parameter logic [3:0] DEVICE_CLASS = 4'h5,   // arbitrary value
    parameter logic [7:0] PART_CODE_LOW = 8'hA1, // arbitrary value
    parameter logic [7:0] PART_CODE_HIGH = 8'h3C, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h02, // arbitrary value
    parameter logic [7:0] MAKER_CODE_LOW = 8'h9E, // arbitrary value
    parameter logic [7:0] MAKER_CODE_HIGH = 8'h6B // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output scr_ctrl_t ctrl,
    output logic core_enable,
    output logic low_power_mode
);
    // synchronised pins and edge detection
    scr_pins_t pins;          // pin levels after two flops
    logic sclk_q;             // previous synchronised clock level
    logic sclk_rise;          // rising serial clock edge seen
    logic sclk_fall;          // falling serial clock edge seen

    // transaction state
    logic [15:0] rx_data;     // last sixteen bits received
    logic instr_done;         // instruction complete, pulse
    logic byte_done;          // data byte complete, pulse
    logic [14:0] addr;        // current register address
    logic is_read;            // transaction direction
    logic stopped;            // single access already used
    logic load;               // reload transmit byte, pulse
    logic [7:0] tx_byte;      // byte handed to the shifter
    logic [7:0] rd_data;      // read value at the current address

    // writable storage
    logic [7:0] regs [SCR_NUM_RW];
    logic [7:0] next_regs [SCR_NUM_RW];

    // decoded controls
    logic ascend;             // streaming direction
    logic single;             // single access per transaction
    logic byte_ok;            // byte counts for this transaction
    logic wr_en;              // register write this cycle
    logic [3:0] wr_idx;       // storage index being written
    logic [7:0] wr_data;      // byte being written
    logic soft_rst;           // soft reset request this cycle
    logic pd_ow;              // power mode write that overwrites power-down bytes
    logic [7:0] pd_val;       // value for that overwrite
    logic step;               // advance the address
    logic [14:0] next_addr;   // address after one streaming step

    // map an address onto the storage index
    function automatic logic [3:0] rw_index(input logic [14:0] a);
        logic [3:0] r;
        r = SCR_IDX_NONE;
        unique case (a)
            SCR_OFF_IF_A: r = SCR_IDX_IF_A;
            SCR_OFF_IF_B: r = SCR_IDX_IF_B;
            SCR_OFF_PWR: r = SCR_IDX_PWR;
            SCR_OFF_HYS19: r = SCR_IDX_HYS19;
            SCR_OFF_HYS20: r = SCR_IDX_HYS20;
            SCR_OFF_HYSLT: r = SCR_IDX_HYSLT;
            SCR_OFF_CLR_A: r = SCR_IDX_CLR_A;
            SCR_OFF_CLR_B: r = SCR_IDX_CLR_B;
            SCR_OFF_PD_A: r = SCR_IDX_PD_A;
            SCR_OFF_PD_B: r = SCR_IDX_PD_B;
            SCR_OFF_PD_C: r = SCR_IDX_PD_C;
            SCR_OFF_TRIG: r = SCR_IDX_TRIG;
            default: r = SCR_IDX_NONE;
        endcase
        return r;
    endfunction

    // default value of each storage entry
    function automatic logic [7:0] rst_value(input int i);
        logic [7:0] v;
        v = SCR_RST_ZERO;
        if (i == int'(SCR_IDX_IF_A)) begin
            v = SCR_RST_IF_A;
        end else if (i == int'(SCR_IDX_IF_B)) begin
            v = SCR_RST_IF_B;
        end else if (i == int'(SCR_IDX_PWR)) begin
            v = SCR_RST_PWR;
        end else if (i >= int'(SCR_IDX_HYS19) && i <= int'(SCR_IDX_HYSLT)) begin
            v = SCR_RST_HYS;
        end
        return v;
    endfunction

    // pin synchroniser; reset levels match idle pins, so no false edge follows reset
    scr_sync2 #(
        .W(3),
        .RST_VAL(SCR_RST_PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({spi_cs_n, spi_sclk, spi_mosi}),
        .q(pins)
    );

    // previous serial clock level for edge detection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0; // serial clock idles low in mode 0
        end else begin
            sclk_q <= pins.sclk;
        end
    end

    // one-cycle pulses on each synchronised serial clock edge
    assign sclk_rise = pins.sclk && !sclk_q;
    assign sclk_fall = !pins.sclk && sclk_q;

    // framing and shift registers
    scr_shift u_shift (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .cs_n(pins.cs_n),
        .rise(sclk_rise),
        .fall(sclk_fall),
        .mosi(pins.mosi),
        .load(load),
        .load_data(tx_byte),
        .rx_data(rx_data),
        .instr_done(instr_done),
        .byte_done(byte_done),
        .miso(spi_miso)
    );

    // sdo is driven only while selected
    assign spi_miso_oe = !pins.cs_n;

    // interface fields
    assign ascend = regs[SCR_IDX_IF_A][SCR_ASCEND_BIT];
    assign single = regs[SCR_IDX_IF_B][SCR_SINGLE_BIT];

    // write decode
    assign byte_ok = byte_done && !stopped;
    assign wr_data = rx_data[7:0];
    assign wr_idx = rw_index(addr);
    assign wr_en = byte_ok && !is_read && (wr_idx != SCR_IDX_NONE);
    assign soft_rst = wr_en && (wr_idx == SCR_IDX_IF_A) && wr_data[SCR_SOFT_RESET_BIT];
    assign pd_ow = wr_en && (wr_idx == SCR_IDX_PWR)
        && (wr_data[1:0] == SCR_PMODE_LOW || wr_data[1:0] == SCR_PMODE_NORMAL);
    assign pd_val = (wr_data[1:0] == SCR_PMODE_LOW) ? SCR_PD_ALL : SCR_RST_ZERO;

    // streaming step: 15-bit arithmetic wraps between top and zero
    assign step = byte_ok && !single;
    assign next_addr = ascend ? addr + SCR_ADDR_STEP : addr - SCR_ADDR_STEP;

    // address, direction and single-access state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            addr <= 15'h0000;
            is_read <= 1'b0;
            stopped <= 1'b0;
            load <= 1'b0;
        end else begin
            // reload the transmit byte after each instruction or byte
            load <= instr_done || byte_done;
            if (pins.cs_n) begin
                stopped <= 1'b0;
            end else if (instr_done) begin
                addr <= rx_data[14:0];
                is_read <= rx_data[SCR_READ_BIT];
                stopped <= 1'b0;
            end else if (byte_ok) begin
                if (step) begin
                    addr <= next_addr;
                end else begin
                    stopped <= 1'b1;
                end
            end
        end
    end

    // next value of each writable entry
    genvar gi;
    for (gi = 0; gi < SCR_NUM_RW; gi++) begin : g_reg
        always_comb begin
            next_regs[gi] = regs[gi];
            if (soft_rst && gi >= int'(SCR_IDX_FIRST_SOFT)) begin
                next_regs[gi] = rst_value(gi);
            end else if (wr_en && wr_idx == 4'(gi)) begin
                next_regs[gi] = wr_data;
                if (gi == int'(SCR_IDX_IF_A)) begin
                    next_regs[gi][SCR_SOFT_RESET_BIT] = 1'b0;
                end
            end else if (pd_ow && (gi == int'(SCR_IDX_PD_A) || gi == int'(SCR_IDX_PD_B))) begin
                next_regs[gi] = pd_val;
            end
        end

        // storage flop
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                regs[gi] <= rst_value(gi);
            end else begin
                regs[gi] <= next_regs[gi];
            end
        end
    end

    // read mux: identification constants, storage, zero elsewhere
    always_comb begin
        rd_data = SCR_RST_ZERO;
        unique case (addr)
            SCR_OFF_CLASS: rd_data = {4'h0, DEVICE_CLASS};
            SCR_OFF_PART_LO: rd_data = PART_CODE_LOW;
            SCR_OFF_PART_HI: rd_data = PART_CODE_HIGH;
            SCR_OFF_REV: rd_data = REVISION_CODE;
            SCR_OFF_MAKER_LO: rd_data = MAKER_CODE_LOW;
            SCR_OFF_MAKER_HI: rd_data = MAKER_CODE_HIGH;
            default: begin
                if (wr_idx != SCR_IDX_NONE) begin
                    rd_data = regs[wr_idx];
                end
            end
        endcase
    end

    // byte sent next: zero for writes or once the single access is used
    assign tx_byte = (is_read && !stopped) ? rd_data : SCR_RST_ZERO;

    // power state decode
    assign core_enable = (ctrl.power_mode == SCR_PMODE_NORMAL);
    assign low_power_mode = (ctrl.power_mode == SCR_PMODE_LOW);

    // register contents to the chip
    assign ctrl.power_mode = regs[SCR_IDX_PWR][1:0];
    assign ctrl.input19_hysteresis = regs[SCR_IDX_HYS19];
    assign ctrl.input20_hysteresis = regs[SCR_IDX_HYS20];
    assign ctrl.local_temp_hysteresis = regs[SCR_IDX_HYSLT];
    assign ctrl.output_clear_a = regs[SCR_IDX_CLR_A];
    assign ctrl.output_clear_b = regs[SCR_IDX_CLR_B];
    assign ctrl.power_down_a = regs[SCR_IDX_PD_A];
    assign ctrl.power_down_b = regs[SCR_IDX_PD_B];
    assign ctrl.power_down_c = regs[SCR_IDX_PD_C];
    assign ctrl.conversion_trigger = regs[SCR_IDX_TRIG];

    // checks on the register behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_SOFT_RST_DEFAULTS: assert property (
        soft_rst |=> regs[SCR_IDX_PWR] == SCR_RST_PWR && regs[SCR_IDX_PD_A] == SCR_RST_ZERO
            && regs[SCR_IDX_HYS19] == SCR_RST_HYS)
        else $error("soft reset did not restore defaults");
    AST_SOFT_RST_KEEPS_IF: assert property (
        soft_rst |=> $stable(regs[SCR_IDX_IF_B]) && !regs[SCR_IDX_IF_A][SCR_SOFT_RESET_BIT])
        else $error("soft reset touched interface register or did not self clear");
    AST_ASCEND_STEP: assert property (
        step && ascend |=> addr == 15'($past(addr) + SCR_ADDR_STEP))
        else $error("ascending step wrong");
    AST_ASCEND_WRAP: assert property (
        step && ascend && addr == SCR_ADDR_TOP |=> addr == 15'h0000)
        else $error("ascending wrap wrong");
    AST_DESCEND_WRAP: assert property (
        step && !ascend && addr == 15'h0000 |=> addr == SCR_ADDR_TOP)
        else $error("descending wrap wrong");
    AST_SINGLE_STOPS: assert property (
        byte_done && single && !stopped && !instr_done && !pins.cs_n
            |=> stopped && $stable(addr) ##1 !wr_en)
        else $error("single access did not stop the transaction");
    AST_POWER_NORMAL: assert property (
        regs[SCR_IDX_PWR][1:0] == SCR_PMODE_NORMAL |-> core_enable && !low_power_mode)
        else $error("normal mode not decoded");
    AST_POWER_LOW: assert property (
        regs[SCR_IDX_PWR][1:0] == SCR_PMODE_LOW |-> low_power_mode && !core_enable)
        else $error("low power mode not decoded");
    AST_PD_OVERWRITE: assert property (
        pd_ow && wr_data[1:0] == SCR_PMODE_LOW |=> ctrl.power_down_a == SCR_PD_ALL
            && ctrl.power_down_b == SCR_PD_ALL)
        else $error("power-down bytes not overwritten");
    AST_PD_NOT_HELD: assert property (
        wr_en && wr_idx == SCR_IDX_PD_A && !soft_rst |=> ctrl.power_down_a == $past(wr_data))
        else $error("power-down byte held by power mode");
    AST_ID_READ: assert property (
        load && is_read && !stopped && addr == SCR_OFF_CLASS
            |=> $past(tx_byte) == {4'h0, DEVICE_CLASS} ##0 $past(rd_data[7:4]) == 4'h0)
        else $error("device class read wrong");
    AST_ID_CODES: assert property (
        addr == SCR_OFF_MAKER_HI && is_read |-> tx_byte == MAKER_CODE_HIGH
            || stopped)
        else $error("maker code high byte read wrong");

    // descending step, tail defaults, refused bytes, power-down hold, id bytes
    AST_DESCEND_STEP: assert property (
        step && !ascend |=> addr == 15'($past(addr) - SCR_ADDR_STEP))
        else $error("descending step wrong");
    AST_SOFT_RST_TAIL: assert property (
        soft_rst |=> regs[SCR_IDX_PD_B] == SCR_RST_ZERO && regs[SCR_IDX_TRIG] == SCR_RST_ZERO
            && regs[SCR_IDX_HYSLT] == SCR_RST_HYS && regs[SCR_IDX_CLR_A] == SCR_RST_ZERO)
        else $error("soft reset left a tail register changed");
    AST_SINGLE_READS_ZERO: assert property (
        load && stopped |=> !spi_miso)
        else $error("refused byte did not read as zero");
    AST_SINGLE_NO_WRITE: assert property (
        byte_done && stopped && !instr_done |=> $stable(addr)
            && $stable(regs[SCR_IDX_PWR]) && $stable(regs[SCR_IDX_HYS19]))
        else $error("refused byte changed the address or a register");
    AST_PD_ONLY_ONCE: assert property (
        !pd_ow && !wr_en && !soft_rst |=> $stable(ctrl.power_down_a)
            && $stable(ctrl.power_down_b))
        else $error("power-down bytes changed without a write");
    AST_CLASS_UPPER_ZERO: assert property (
        addr == SCR_OFF_CLASS |-> rd_data[7:4] == 4'h0 && rd_data[3:0] == DEVICE_CLASS)
        else $error("device class byte wrong");
    AST_PART_HIGH: assert property (
        addr == SCR_OFF_PART_HI && is_read && !stopped |-> tx_byte == PART_CODE_HIGH)
        else $error("part code high byte read wrong");
    AST_REVISION: assert property (
        addr == SCR_OFF_REV && is_read && !stopped |-> tx_byte == REVISION_CODE)
        else $error("revision code read wrong");

    COV_SOFT_RESET: cover property (soft_rst);
    COV_DESCEND_WRAP: cover property (step && !ascend && addr == 15'h0000);
    COV_SINGLE: cover property (byte_done && stopped);
    COV_LOW_POWER: cover property (pd_ow ##1 low_power_mode);
    COV_ASCEND_WRAP: cover property (step && ascend && addr == SCR_ADDR_TOP);
endmodule

/* File: scr_pkg.sv */
// package: constants, map and carrier types of the serial configuration and id register block
package scr_pkg;
    // serial frame layout
    localparam int SCR_ADDR_W = 15;              // register address width
    localparam logic [4:0] SCR_INSTR_LAST = 5'h0F; // last bit index of the 16-bit instruction
    localparam logic [4:0] SCR_BYTE_LAST = 5'h07;  // last bit index of a data byte
    localparam int SCR_READ_BIT = 15;            // instruction bit: one reads, zero writes
    localparam logic [14:0] SCR_ADDR_STEP = 15'h0001; // streaming address step
    localparam logic [14:0] SCR_ADDR_TOP = 15'h7FFF;  // highest address, wrap point

    // register offsets
    localparam logic [14:0] SCR_OFF_IF_A = 15'h0000;
    localparam logic [14:0] SCR_OFF_IF_B = 15'h0001;
    localparam logic [14:0] SCR_OFF_PWR = 15'h0002;
    localparam logic [14:0] SCR_OFF_CLASS = 15'h0003;
    localparam logic [14:0] SCR_OFF_PART_LO = 15'h0004;
    localparam logic [14:0] SCR_OFF_PART_HI = 15'h0005;
    localparam logic [14:0] SCR_OFF_REV = 15'h0006;
    localparam logic [14:0] SCR_OFF_MAKER_LO = 15'h000C;
    localparam logic [14:0] SCR_OFF_MAKER_HI = 15'h000D;
    localparam logic [14:0] SCR_OFF_HYS19 = 15'h00A3;
    localparam logic [14:0] SCR_OFF_HYS20 = 15'h00A4;
    localparam logic [14:0] SCR_OFF_HYSLT = 15'h00A5;
    localparam logic [14:0] SCR_OFF_CLR_A = 15'h00B0;
    localparam logic [14:0] SCR_OFF_CLR_B = 15'h00B1;
    localparam logic [14:0] SCR_OFF_PD_A = 15'h00B2;
    localparam logic [14:0] SCR_OFF_PD_B = 15'h00B3;
    localparam logic [14:0] SCR_OFF_PD_C = 15'h00B4;
    localparam logic [14:0] SCR_OFF_TRIG = 15'h00C0;

    // index of each writable register in the storage array
    localparam int SCR_NUM_RW = 12;
    localparam logic [3:0] SCR_IDX_IF_A = 4'h0;
    localparam logic [3:0] SCR_IDX_IF_B = 4'h1;
    localparam logic [3:0] SCR_IDX_PWR = 4'h2;
    localparam logic [3:0] SCR_IDX_HYS19 = 4'h3;
    localparam logic [3:0] SCR_IDX_HYS20 = 4'h4;
    localparam logic [3:0] SCR_IDX_HYSLT = 4'h5;
    localparam logic [3:0] SCR_IDX_CLR_A = 4'h6;
    localparam logic [3:0] SCR_IDX_CLR_B = 4'h7;
    localparam logic [3:0] SCR_IDX_PD_A = 4'h8;
    localparam logic [3:0] SCR_IDX_PD_B = 4'h9;
    localparam logic [3:0] SCR_IDX_PD_C = 4'hA;
    localparam logic [3:0] SCR_IDX_TRIG = 4'hB;
    localparam logic [3:0] SCR_IDX_NONE = 4'hF;   // not a writable register
    localparam logic [3:0] SCR_IDX_FIRST_SOFT = 4'h2; // first index restored to its default by soft reset

    // reset values
    localparam logic [7:0] SCR_RST_IF_A = 8'h30;
    localparam logic [7:0] SCR_RST_IF_B = 8'h00;
    localparam logic [7:0] SCR_RST_PWR = 8'h03;
    localparam logic [7:0] SCR_RST_HYS = 8'h08;
    localparam logic [7:0] SCR_RST_ZERO = 8'h00;
    localparam logic [7:0] SCR_PD_ALL = 8'hFF;    // power-down bytes when entering low power
    localparam logic [2:0] SCR_RST_PINS = 3'h4;   // pin flops in reset: cs_n high, sclk and mosi low

    // field positions
    localparam int SCR_SOFT_RESET_BIT = 7;       // in interface_config_a
    localparam int SCR_ASCEND_BIT = 5;           // in interface_config_a
    localparam int SCR_SINGLE_BIT = 7;           // single_transfer_select in interface_config_b
    localparam logic [1:0] SCR_PMODE_NORMAL = 2'b00;
    localparam logic [1:0] SCR_PMODE_LOW = 2'b11;

    // synchronised serial pins
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } scr_pins_t;

    // register contents steering the rest of the chip
    typedef struct packed {
        logic [1:0] power_mode;
        logic [7:0] input19_hysteresis;
        logic [7:0] input20_hysteresis;
        logic [7:0] local_temp_hysteresis;
        logic [7:0] output_clear_a;
        logic [7:0] output_clear_b;
        logic [7:0] power_down_a;
        logic [7:0] power_down_b;
        logic [7:0] power_down_c;
        logic [7:0] conversion_trigger;
    } scr_ctrl_t;
endpackage

/* File: scr_sync2.sv */
// two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module scr_sync2 #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1 // idle level of each pin, held in reset
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // first stage, read only by the second
    genvar i;
    // one pair of flops per bit; reset levels are constants per bit
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                meta[i] <= RST_VAL[i];
                q[i] <= RST_VAL[i];
            end else begin
                meta[i] <= d[i];
                q[i] <= meta[i];
            end
        end
    end
endmodule

/* File: scr_shift.sv */
// serial shifter: instruction and byte framing, receive and transmit shift registers
`timescale 1ns/100ps
module scr_shift
    import scr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic rise,
    input wire logic fall,
    input wire logic mosi,
    input wire logic load,
    input wire logic [7:0] load_data,
    output logic [15:0] rx_data,
    output logic instr_done,
    output logic byte_done,
    output logic miso
);
    logic [4:0] cnt;      // bit count inside instruction or byte
    logic in_instr;       // still receiving the instruction
    logic [7:0] tx;       // transmit shift register, msb first
    logic fresh;          // msb just loaded, hold it over the next falling edge

    wire last_bit = in_instr ? (cnt == SCR_INSTR_LAST) : (cnt == SCR_BYTE_LAST);

    // receive side: shift on rising edges, frame restarts while deselected
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 5'h00;
            in_instr <= 1'b1;
            rx_data <= 16'h0000;
            instr_done <= 1'b0;
            byte_done <= 1'b0;
        end else begin
            instr_done <= !cs_n && rise && last_bit && in_instr;
            byte_done <= !cs_n && rise && last_bit && !in_instr;
            if (cs_n) begin
                cnt <= 5'h00;
                in_instr <= 1'b1;
            end else if (rise) begin
                rx_data <= {rx_data[14:0], mosi};
                cnt <= last_bit ? 5'h00 : cnt + 5'h01;
                if (last_bit) begin
                    in_instr <= 1'b0;
                end
            end
        end
    end

    // transmit side: load, then shift on each falling edge after the first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx <= 8'h00;
            fresh <= 1'b0;
        end else if (cs_n) begin
            tx <= 8'h00;
            fresh <= 1'b0;
        end else if (load) begin
            tx <= load_data;
            fresh <= 1'b1;
        end else if (fall) begin
            fresh <= 1'b0;
            if (!fresh) begin
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    assign miso = tx[7];
endmodule

/* File: scr_host.sv */
// serial host model: drives mode-0 frames and collects one byte per data slot
`timescale 1ns/100ps
module scr_host (
    input wire logic ref_clk,
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    // idle levels at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // outside frames the data line keeps changing, never a stale bit
    always @(posedge ref_clk) begin
        if (cs_n) begin
            mosi <= ~mosi;
        end
    end
    // wait n clocks, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // one bit: data set while low, miso taken as sclk rises
    task automatic bit_x(input logic b, output logic r);
        mosi = b;
        cyc(8);
        sclk = 1'b1;
        r = miso;
        cyc(8);
        sclk = 1'b0;
    endtask
    // select, then the 16-bit instruction msb first
    task automatic start(input logic [15:0] instr);
        logic r;
        cs_n = 1'b0;
        cyc(4);
        for (int i = 15; i >= 0; i--) begin
            bit_x(instr[i], r);
        end
    endtask
    // one data byte out and in, result flagged for one clock
    task automatic xbyte(input logic [7:0] w);
        logic [7:0] r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(w[i], r[i]);
        end
        rx_byte = r;
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
    endtask
    // deselect and keep the gap between frames
    task automatic stop();
        cyc(1);
        cs_n = 1'b1;
        cyc(4);
    endtask
endmodule

/* File: spi_config_and_id_registers_test.sv */
// self-checking bench of the serial configuration and id registers
`timescale 1ns/100ps
module spi_config_and_id_registers_test;
    import scr_pkg::*;
    logic ref_clk;
    logic rstn;
    logic sclk, cs_n, mosi, miso, miso_oe, core_en, low_pw, rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] r;
    scr_ctrl_t ctrl;
    logic [7:0] exp_q[$]; // expected read bytes, oldest first
    int err_total;
    int compares;
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // identification values are the block's arbitrary defaults
    scr_regs u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .ctrl(ctrl),
        .core_enable(core_en), .low_power_mode(low_pw));
    scr_host u_host (.ref_clk(ref_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .rx_byte(rx_byte), .rx_valid(rx_valid));
    // byte result check
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected byte at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // control outputs check: miso enable, core enable, low power, power-down a and b
    task automatic cmp_ctrl(input logic [18:0] e);
        compares++;
        if ({miso_oe, core_en, low_pw, ctrl.power_down_a, ctrl.power_down_b} !== e) begin
            err_total++;
            $display("unexpected ctrl at %0t: exp %h got %h", $time, e,
                {miso_oe, core_en, low_pw, ctrl.power_down_a, ctrl.power_down_b});
        end
    endtask
    // verdict and end of run
    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watcher: each byte the host collects takes the oldest note
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("unexpected extra byte at %0t: exp %h got %h", $time, 8'h00, rx_byte);
            end else begin
                cmp_byte(exp_q.pop_front(), rx_byte);
            end
        end
    end
    // single-byte write frame; a write returns zeros on miso
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_host.start({1'b0, a});
        exp_q.push_back(8'h00);
        u_host.xbyte(d);
        u_host.stop();
    endtask
    // streamed read frame, one note per byte
    task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
        u_host.start({1'b1, a});
        foreach (e[i]) begin
            exp_q.push_back(e[i]);
            u_host.xbyte(8'h00);
        end
        u_host.stop();
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        err_total = 0;
        compares = 0;
        void'($urandom(32'h4e38));
        r = 8'($urandom) | 8'h01;
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        u_host.cyc(4);
        cmp_ctrl({1'b0, 1'b0, 1'b1, 8'h00, 8'h00});
        rd(15'h0000, '{8'h30, 8'h00, 8'h03, 8'h05, 8'hA1, 8'h3C, 8'h02});
        rd(SCR_OFF_MAKER_LO, '{8'h9E, 8'h6B});
        wr(SCR_OFF_PWR, 8'h00);
        cmp_ctrl({1'b0, 1'b1, 1'b0, 8'h00, 8'h00});
        wr(SCR_OFF_PD_A, r);
        wr(SCR_OFF_PWR, 8'h03);
        cmp_ctrl({1'b0, 1'b0, 1'b1, 8'hFF, 8'hFF});
        wr(SCR_OFF_PD_B, r);
        cmp_ctrl({1'b0, 1'b0, 1'b1, 8'hFF, r});
        rd(SCR_OFF_PD_A, '{8'hFF, r});
        rd(SCR_ADDR_TOP, '{8'h00, 8'h30});
        wr(SCR_OFF_IF_A, 8'h10);
        rd(SCR_OFF_IF_B, '{8'h00, 8'h10, 8'h00});
        wr(SCR_OFF_IF_A, 8'h30);
        wr(SCR_OFF_IF_B, 8'h80);
        rd(SCR_OFF_PART_LO, '{8'hA1, 8'h00});
        wr(SCR_OFF_IF_B, 8'h20);
        wr(SCR_OFF_HYS19, r);
        wr(SCR_OFF_IF_A, 8'h30);
        rd(SCR_OFF_HYS19, '{r});
        wr(SCR_OFF_IF_A, 8'hB0);
        rd(SCR_OFF_IF_A, '{8'h30, 8'h20, 8'h03});
        rd(SCR_OFF_HYS19, '{8'h08});
        cmp_ctrl({1'b0, 1'b0, 1'b1, 8'h00, 8'h00});
        u_host.cyc(4);
        if (exp_q.size() != 0) begin
            err_total++;
        end
        end_sim();
    end
endmodule
